//--- bench/lsc_partner.sv
// Link partner and LTSSM stand-in for the speed control block
`timescale 1ns/100ps
module lsc_partner (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // Bench commands
   input  wire logic                adv_p,
   input  wire logic                fail_next,
   input  wire logic                reliab_down,
   // Port control
   input  wire lsc_pkg::lsc_ltssm_t ctl,
   // LTSSM observation
   output logic                     dl_active,
   output logic                     in_detect,
   output logic                     cfg_entry,
   output logic                     partner_5g,
   output logic                     link_at_5g,
   output logic                     change_done,
   output logic                     change_fail
);
   logic [3:0] cnt_r;
   logic       chg_r;
   logic       up5_r;
   // Advertisement only holds in the recording cycle
   assign partner_5g = cfg_entry ? adv_p : ~adv_p;
   always_ff @(posedge clk) begin
      cfg_entry   <= 1'b0;
      change_done <= 1'b0;
      change_fail <= 1'b0;
      if (rst || ctl.to_detect) begin
         cnt_r      <= 4'h8;
         chg_r      <= 1'b0;
         dl_active  <= 1'b0;
         in_detect  <= 1'b1;
         link_at_5g <= 1'b0;
      end else if (ctl.retrain) begin
         chg_r     <= 1'b1;
         up5_r     <= ctl.speed_req ? ctl.speed_5g : link_at_5g;
         cnt_r     <= 4'h3;
         cfg_entry <= 1'b1;
      end else if (cnt_r != 4'h0) begin
         cnt_r <= cnt_r - 4'h1;
         if (!chg_r && cnt_r == 4'h5) begin
            in_detect <= 1'b0;
            cfg_entry <= 1'b1;
         end
         if (!chg_r && cnt_r == 4'h1)
            dl_active <= 1'b1;
         if (chg_r && cnt_r == 4'h1) begin
            chg_r <= 1'b0;
            if (up5_r && !(adv_p && ctl.adv_5g && !fail_next))
               change_fail <= 1'b1;
            else begin
               link_at_5g  <= up5_r;
               change_done <= 1'b1;
            end
         end
      end
      if (reliab_down)
         link_at_5g <= 1'b0;
   end
endmodule

//--- bench/lsc_speed_ctl_bench.sv
// Self-checking bench for the link speed control block
`timescale 1ns/100ps
module lsc_speed_ctl_bench;
   logic                clk, rst, adv_p, fail_next, rel, pchg, pauto, ds;
   lsc_pkg::lsc_req_t   req;
   lsc_pkg::lsc_ltssm_t ctl;
   logic [31:0]         rdata, r;
   logic                dla, det, cfe, p5g, at5, cdn, cfl, ntf;
   int                  fails = 0, total_checks = 0;
   int                  nreq = 0, nauto = 0, ndet = 0;
   lsc_speed_ctl u_dut (.clk(clk), .rst(rst), .is_downstream(ds),
      .reg_req(req), .reg_rdata(rdata), .dl_active(dla), .in_detect(det),
      .cfg_entry(cfe), .partner_5g(p5g), .link_at_5g(at5),
      .change_done(cdn), .change_fail(cfl), .reliab_down(rel),
      .partner_chg(pchg), .partner_auto(pauto), .ltssm_ctl(ctl),
      .bw_notify(ntf));
   lsc_partner u_partner (.clk(clk), .rst(rst), .adv_p(adv_p),
      .fail_next(fail_next), .reliab_down(rel), .ctl(ctl), .dl_active(dla),
      .in_detect(det), .cfg_entry(cfe), .partner_5g(p5g),
      .link_at_5g(at5), .change_done(cdn), .change_fail(cfl));
   // ****************************************
   // Bus tasks and checks
   // ****************************************
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] m, e);
      logic [31:0] d;
      req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk);
      req <= '0;
      #1 d = rdata;
      @(posedge clk);
      chk(d & m, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wt(input logic v);
      for (int i = 0; i < 80 && at5 !== v; i++) @(posedge clk);
   endtask
   task automatic pchange(input logic au);
      pchg  <= 1'b1;
      pauto <= au;
      @(posedge clk);
      pchg  <= 1'b0;
      pauto <= 1'b0;
      idle(2);
   endtask
   task automatic tend(input int n);
      $display("test %0d done", n);
   endtask
   task automatic test_done;
      $display("checks=%0d fails=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      nreq  <= nreq + (ctl.speed_req === 1'b1);
      nauto <= nauto + (ctl.auto_chg !== 1'b0);
      ndet  <= ndet + (ctl.to_detect === 1'b1);
   end
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #20000;
      fails++;
      test_done;
   end
   initial begin
      r = $urandom(32'h80206ba3);
      {rst, adv_p, fail_next, rel, pchg, pauto} = 6'h30;
      ds = 1'b1;
      req = '0;
      idle(20);
      rst <= 1'b0;
      rchk(4'h2, 32'h2f, 32'h2);
      chk(ctl.adv_5g, 1'b1);
      wt(1'b1);
      rchk(4'h1, 32'hc00f, 32'h2);
      tend(1);
      rel <= 1'b1;
      @(posedge clk);
      rel <= 1'b0;
      idle(20);
      rchk(4'h1, 32'h400f, 32'h4001);
      chk(ctl.adv_5g, 1'b1);
      chk(ntf, 1'b0);
      wr(4'h1, 32'hc000);
      wr(4'h0, 32'h420);
      wt(1'b1);
      rchk(4'h1, 32'h400f, 32'h4002);
      wr(4'h2, 32'h1);
      wr(4'h0, 32'h420);
      wt(1'b0);
      chk(ctl.adv_5g, 1'b0);
      wr(4'h2, 32'h22);
      rchk(4'h2, 32'h2f, 32'h2);
      tend(2);
      fail_next <= 1'b1;
      wr(4'h0, 32'h420);
      idle(30);
      fail_next <= 1'b0;
      chk(nreq, 4);
      chk(at5, 1'b0);
      adv_p <= 1'b0;
      wr(4'h4, 32'h1);
      idle(40);
      chk(ndet, 1);
      rchk(4'h1, 32'h4000, 32'h4000);
      wr(4'h0, 32'h420);
      idle(20);
      chk({at5, 8'(nreq)}, 9'h4);
      tend(3);
      adv_p <= 1'b1;
      wr(4'h3, 32'h1);
      wr(4'h4, 32'h1);
      idle(40);
      chk({at5, 8'(nreq)}, 9'h4);
      wr(4'h3, 32'h0);
      wr(4'h1, 32'hc000);
      wr(4'h4, 32'h1);
      wt(1'b1);
      rchk(4'h1, 32'h400f, 32'h2);
      pchange(1'b1);
      rchk(4'h1, 32'hc000, 32'h8000);
      wr(4'h1, 32'hc000);
      pchange(1'b0);
      rchk(4'h1, 32'hc000, 32'h4000);
      chk(ntf, 1'b1);
      wr(4'h0, 32'h0);
      idle(2);
      chk(ntf, 1'b0);
      ds <= 1'b0;
      wr(4'h4, 32'h1);
      idle(40);
      chk(at5, 1'b0);
      ds <= 1'b1;
      tend(4);
      for (int i = 0; i < 6; i++) begin
         r[3:0] = 4'(5 + $urandom_range(10));
         wr(r[3:0], $urandom);
         rchk(r[3:0], 32'hffffffff, 32'h0);
      end
      chk(nauto, 0);
      tend(5);
      test_done;
   end
endmodule

//--- hdl/lsc_speed_ctl.sv
// Link speed control for one switch port
`timescale 1ns/100ps

module lsc_speed_ctl (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Port role
   input  wire logic              is_downstream,
   // Register port
   input  wire lsc_pkg::lsc_req_t reg_req,
   output logic [31:0]            reg_rdata,
   // LTSSM observation
   input  wire logic              dl_active,
   input  wire logic              in_detect,
   input  wire logic              cfg_entry,
   input  wire logic              partner_5g,
   input  wire logic              link_at_5g,
   input  wire logic              change_done,
   input  wire logic              change_fail,
   input  wire logic              reliab_down,
   input  wire logic              partner_chg,
   input  wire logic              partner_auto,
   // LTSSM control and bandwidth notification
   output lsc_pkg::lsc_ltssm_t    ltssm_ctl,
   output logic                   bw_notify
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      lsc_pkg::lsc_state_t st;
      lsc_pkg::lsc_cause_t cause;
      logic [3:0]          target;
      logic                inhibit;
      logic                int_en;
      logic                bw_sts;
      logic                abw_sts;
      logic                partner5;
      logic                cur5;
      logic                adv5;
      logic                auto_done;
      lsc_pkg::lsc_ltssm_t ctl;
      logic [31:0]         rdata;
      logic                notify;
   } lsc_regs_t;

   lsc_regs_t s_r;
   lsc_regs_t s_nxt;

   logic wr_ctl;
   logic wr_ctl2;
   logic wr_cfg0;
   logic wr_st0;
   logic retrain_wr;
   logic full_wr;
   logic want5;

   always_comb begin
      wr_ctl  = reg_req.wr && reg_req.addr == lsc_pkg::LINK_CONTROL_REG_OFS;
      wr_ctl2 = reg_req.wr && reg_req.addr == lsc_pkg::LINK_CONTROL2_REG_OFS;
      wr_cfg0 = reg_req.wr && reg_req.addr == lsc_pkg::PHY_LINK_CFG0_REG_OFS;
      wr_st0  = reg_req.wr &&
                reg_req.addr == lsc_pkg::PHY_LINK_STATE0_REG_OFS;
      retrain_wr = wr_ctl && reg_req.wdata[lsc_pkg::LCTL_RETRAIN_BIT];
      full_wr    = wr_st0 && reg_req.wdata[lsc_pkg::STATE0_FULL_BIT];
      want5      = s_r.target == lsc_pkg::SPEED_5G0;
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.ctl.speed_req = 1'b0;
      s_nxt.ctl.retrain   = 1'b0;
      s_nxt.ctl.to_detect = 1'b0;
      s_nxt.ctl.auto_chg  = 1'b0;
      s_nxt.cur5 = link_at_5g;
      if (wr_ctl)
         s_nxt.int_en = reg_req.wdata[lsc_pkg::LCTL_BW_INTEN_BIT];
      if (wr_ctl2)
         s_nxt.target = reg_req.wdata[lsc_pkg::LCTL2_TARGET_LSB +: 4];
      if (wr_cfg0)
         s_nxt.inhibit = reg_req.wdata[lsc_pkg::CFG0_INHIBIT_BIT];
      if (cfg_entry)
         s_nxt.partner5 = partner_5g;

      // ****************************************
      // Status flags
      // ****************************************
      // Status clears are write-one-to-clear; hardware set wins below
      if (reg_req.wr && reg_req.addr == lsc_pkg::LINK_STATUS_REG_OFS) begin
         if (reg_req.wdata[lsc_pkg::LSTS_BW_MGMT_BIT])
            s_nxt.bw_sts = 1'b0;
         if (reg_req.wdata[lsc_pkg::LSTS_AUTO_BW_BIT])
            s_nxt.abw_sts = 1'b0;
      end
      // Advertise 5.0 only while the target is 5.0
      if (wr_ctl2)
         s_nxt.adv5 = reg_req.wdata[lsc_pkg::LCTL2_TARGET_LSB +: 4] ==
                      lsc_pkg::SPEED_5G0;
      if (retrain_wr)
         s_nxt.bw_sts = 1'b1;
      if (partner_chg && is_downstream) begin
         if (partner_auto)
            s_nxt.abw_sts = 1'b1;
         else
            s_nxt.bw_sts = 1'b1;
      end
      if (reliab_down && s_r.cur5 && is_downstream)
         s_nxt.bw_sts = 1'b1;

      // ****************************************
      // Speed control
      // ****************************************
      unique case (s_r.st)
         lsc_pkg::ST_DOWN: begin
            s_nxt.auto_done = 1'b0;
            if (dl_active)
               s_nxt.st = lsc_pkg::ST_UP;
         end
         lsc_pkg::ST_UP: begin
            if (!dl_active) begin
               s_nxt.st = lsc_pkg::ST_DOWN;
            end else if (retrain_wr) begin
               // Speed_Change only toward an advertised rate
               s_nxt.ctl.retrain  = 1'b1;
               s_nxt.ctl.speed_5g = want5;
               s_nxt.ctl.speed_req = (want5 != s_r.cur5) &&
                  (!want5 || s_r.partner5);
               s_nxt.cause = lsc_pkg::CH_SW;
               s_nxt.st = lsc_pkg::ST_CHANGE;
            end else if (!s_r.auto_done && is_downstream && want5 &&
                         !s_r.inhibit && !s_r.cur5 && s_r.partner5) begin
               s_nxt.ctl.retrain   = 1'b1;
               s_nxt.ctl.speed_req = 1'b1;
               s_nxt.ctl.speed_5g  = 1'b1;
               s_nxt.cause = lsc_pkg::CH_AUTO;
               s_nxt.auto_done = 1'b1;
               s_nxt.st = lsc_pkg::ST_CHANGE;
            end
         end
         lsc_pkg::ST_CHANGE: begin
            // Failure reverts to 2.5; auto_done blocks any autonomous retry, software retrain still allowed
            if (change_fail)
               s_nxt.auto_done = 1'b1;
            if (change_done || change_fail)
               s_nxt.st = lsc_pkg::ST_UP;
            if (!dl_active)
               s_nxt.st = lsc_pkg::ST_DOWN;
         end
         lsc_pkg::ST_RETRAIN: begin
            if (in_detect)
               s_nxt.st = lsc_pkg::ST_DOWN;
         end
         default: s_nxt.st = lsc_pkg::ST_DOWN;
      endcase
      // A full retrain write sends the LTSSM to Detect and cancels any speed request
      if (full_wr) begin
         s_nxt.ctl.to_detect = 1'b1;
         s_nxt.ctl.speed_req = 1'b0;
         s_nxt.st = lsc_pkg::ST_RETRAIN;
      end
      s_nxt.ctl.adv_5g = s_nxt.adv5;
      s_nxt.notify = s_nxt.bw_sts && s_nxt.int_en && is_downstream;

      // ****************************************
      // Read data
      // ****************************************
      s_nxt.rdata = 32'h0;
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            lsc_pkg::LINK_CONTROL_REG_OFS:
               s_nxt.rdata[lsc_pkg::LCTL_BW_INTEN_BIT] = s_r.int_en;
            lsc_pkg::LINK_STATUS_REG_OFS: begin
               s_nxt.rdata[lsc_pkg::LSTS_SPEED_LSB +: 4] = s_r.cur5 ?
                  lsc_pkg::SPEED_5G0 : lsc_pkg::SPEED_2G5;
               s_nxt.rdata[lsc_pkg::LSTS_BW_MGMT_BIT] = s_r.bw_sts;
               s_nxt.rdata[lsc_pkg::LSTS_AUTO_BW_BIT] = s_r.abw_sts;
            end
            lsc_pkg::LINK_CONTROL2_REG_OFS:
               s_nxt.rdata[lsc_pkg::LCTL2_TARGET_LSB +: 4] = s_r.target;
            lsc_pkg::PHY_LINK_CFG0_REG_OFS:
               s_nxt.rdata[lsc_pkg::CFG0_INHIBIT_BIT] = s_r.inhibit;
            default: s_nxt.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r          <= '0;
         s_r.st       <= lsc_pkg::ST_DOWN;
         s_r.target   <= lsc_pkg::TARGET_RST;
         s_r.inhibit  <= lsc_pkg::INHIBIT_RST;
         s_r.adv5     <= 1'b1;
         s_r.ctl.adv_5g <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata = s_r.rdata;
   assign ltssm_ctl = s_r.ctl;
   assign bw_notify = s_r.notify;

   // ****************************************
   // Assertions: reset and advertising
   // ****************************************
   target_reset_a: assert property (
      @(posedge clk)
      $fell(rst) |-> s_r.target == lsc_pkg::SPEED_5G0)
      else $error("target not 5.0");

   adv_track_a: assert property (
      @(posedge clk) disable iff (rst)
      wr_ctl2 |=> (ltssm_ctl.adv_5g == want5))
      else $error("advertise mismatch");

   adv_keep_a: assert property (
      @(posedge clk) disable iff (rst)
      reliab_down && !wr_ctl2 |=> ltssm_ctl.adv_5g == $past(s_r.adv5))
      else $error("advertising lost on downgrade");

   adv_drop_a: assert property (
      @(posedge clk) disable iff (rst)
      wr_ctl2 && reg_req.wdata[lsc_pkg::LCTL2_TARGET_LSB +: 4] ==
      lsc_pkg::SPEED_2G5 |=> !ltssm_ctl.adv_5g)
      else $error("5.0 still advertised");

   autochg_a: assert property (
      @(posedge clk) disable iff (rst)
      !ltssm_ctl.auto_chg)
      else $error("autonomous bit set");

   hw_autonomous_speed_disable_zero_a: assert property (
      @(posedge clk) disable iff (rst)
      reg_req.rd && reg_req.addr == lsc_pkg::LINK_CONTROL2_REG_OFS
      |=> !reg_rdata[lsc_pkg::LCTL2_HW_AUTONOMOUS_SPEED_DISABLE_BIT])
      else $error("speed disable bit reads one");

   record_a: assert property (
      @(posedge clk) disable iff (rst)
      cfg_entry |=> s_r.partner5 == $past(partner_5g))
      else $error("partner rates not recorded");

   // ****************************************
   // Assertions: speed changes
   // ****************************************
   up_no_auto_a: assert property (
      @(posedge clk) disable iff (rst)
      !is_downstream && !retrain_wr |=> !ltssm_ctl.speed_req)
      else $error("upstream autonomous upgrade");

   inhibit_a: assert property (
      @(posedge clk) disable iff (rst)
      s_r.inhibit && !retrain_wr |=> !ltssm_ctl.speed_req)
      else $error("upgrade despite inhibit");

   speed_field_a: assert property (
      @(posedge clk) disable iff (rst)
      ##1 1 |-> s_r.cur5 == $past(link_at_5g))
      else $error("current speed stale");

   sw_up_a: assert property (
      @(posedge clk) disable iff (rst)
      s_r.st == lsc_pkg::ST_UP && dl_active && retrain_wr && want5 &&
      !s_r.cur5 && s_r.partner5 && !full_wr
      |=> ltssm_ctl.speed_req && ltssm_ctl.speed_5g)
      else $error("software upgrade not started");

   no_retry_a: assert property (
      @(posedge clk) disable iff (rst)
      s_r.st == lsc_pkg::ST_CHANGE && change_fail && dl_active
      |=> !retrain_wr |=> !ltssm_ctl.speed_req)
      else $error("upgrade retried after failure");

   stay_low_a: assert property (
      @(posedge clk) disable iff (rst)
      s_r.st == lsc_pkg::ST_UP && !s_r.cur5 && s_r.auto_done &&
      !retrain_wr |=> !ltssm_ctl.speed_req)
      else $error("left lower rate on its own");

   full_det_a: assert property (
      @(posedge clk) disable iff (rst)
      full_wr |=> ltssm_ctl.to_detect ##1 !ltssm_ctl.to_detect)
      else $error("full retrain missing");

   unsup_a: assert property (
      @(posedge clk) disable iff (rst)
      ltssm_ctl.speed_req && ltssm_ctl.speed_5g |-> $past(s_r.partner5))
      else $error("unadvertised rate");

   // ****************************************
   // Assertions: status flags
   // ****************************************
   bw_hold_a: assert property (
      @(posedge clk) disable iff (rst)
      !retrain_wr && !reliab_down && !partner_chg &&
      !(reg_req.wr && reg_req.addr == lsc_pkg::LINK_STATUS_REG_OFS)
      |=> s_r.bw_sts == $past(s_r.bw_sts))
      else $error("bandwidth flag moved");

   bw_retrain_a: assert property (
      @(posedge clk) disable iff (rst)
      retrain_wr |=> s_r.bw_sts)
      else $error("retrain not flagged");

   abw_set_a: assert property (
      @(posedge clk) disable iff (rst)
      partner_chg && partner_auto && is_downstream |=> s_r.abw_sts)
      else $error("autonomous flag not set");

   bw_partner_a: assert property (
      @(posedge clk) disable iff (rst)
      partner_chg && !partner_auto && is_downstream |=> s_r.bw_sts)
      else $error("partner change not flagged");

   bw_reliab_a: assert property (
      @(posedge clk) disable iff (rst)
      reliab_down && s_r.cur5 && is_downstream |=> s_r.bw_sts)
      else $error("downgrade not flagged");

   notify_en_a: assert property (
      @(posedge clk) disable iff (rst)
      bw_notify |-> $past(s_r.int_en || wr_ctl))
      else $error("notify without enable");

   // ****************************************
   // Covers
   // ****************************************
   auto_up_c: cover property (@(posedge clk) s_r.cause == lsc_pkg::CH_AUTO);

   sw_chg_c: cover property (@(posedge clk) retrain_wr ##1 ltssm_ctl.retrain);

   full_c: cover property (@(posedge clk) ltssm_ctl.to_detect);

   rel_down_c: cover property (@(posedge clk) reliab_down && s_r.cur5);

   fail_c: cover property (@(posedge clk) change_fail);

endmodule

//--- pkg/lsc_pkg.sv
// Package for the link speed control block
package lsc_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [3:0] LINK_CONTROL_REG_OFS   = 4'h0;
   localparam logic [3:0] LINK_STATUS_REG_OFS    = 4'h1;
   localparam logic [3:0] LINK_CONTROL2_REG_OFS  = 4'h2;
   localparam logic [3:0] PHY_LINK_CFG0_REG_OFS  = 4'h3;
   localparam logic [3:0] PHY_LINK_STATE0_REG_OFS = 4'h4;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int LCTL_RETRAIN_BIT   = 5;
   localparam int LCTL_BW_INTEN_BIT  = 10;
   localparam int LSTS_SPEED_LSB     = 0;
   localparam int LSTS_BW_MGMT_BIT   = 14;
   localparam int LSTS_AUTO_BW_BIT   = 15;
   localparam int LCTL2_TARGET_LSB   = 0;
   localparam int LCTL2_HW_AUTONOMOUS_SPEED_DISABLE_BIT     = 5;
   localparam int CFG0_INHIBIT_BIT   = 0;
   localparam int STATE0_FULL_BIT    = 0;
   localparam int TS_AUTO_CHG_BIT    = 6;

   // ****************************************
   // Speed encodings and reset values
   // ****************************************
   localparam logic [3:0] SPEED_2G5      = 4'h1;
   localparam logic [3:0] SPEED_5G0      = 4'h2;
   localparam logic [3:0] TARGET_RST     = SPEED_5G0;
   localparam logic       INHIBIT_RST    = 1'b0;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      ST_DOWN    = 3'b000,
      ST_UP      = 3'b001,
      ST_CHANGE  = 3'b010,
      ST_RETRAIN = 3'b011
   } lsc_state_t;

   typedef enum logic [1:0] {
      CH_NONE    = 2'b00,
      CH_AUTO    = 2'b01,
      CH_SW      = 2'b10
   } lsc_cause_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } lsc_req_t;

   typedef struct packed {
      logic speed_req;
      logic speed_5g;
      logic retrain;
      logic to_detect;
      logic adv_5g;
      logic auto_chg;
   } lsc_ltssm_t;

endpackage
